/* File: hw/vcr_pkg.sv */
// Purpose: shared constants and carriers for the core register model
// Assumes: 32-bit data words, register port addressed in bytes
// Notes: register offsets are byte addresses on the plain register port

package vcr_pkg;

   // ------------------------------------------------------------
   // widths and sizes
   // ------------------------------------------------------------
   localparam int unsigned VCR_DATA_W = 32;
   localparam int unsigned VCR_NUM_GPR = 128;
   localparam int unsigned VCR_GPR_IDX_W = 7;
   localparam int unsigned VCR_BUS_AW = 10;
   localparam int unsigned VCR_CC_W = 64;

   // ------------------------------------------------------------
   // register port offsets
   // ------------------------------------------------------------
   localparam logic [9:0] VCR_OFS_STATUS = 10'h000;
   localparam logic [9:0] VCR_OFS_DEST_TGT = 10'h004;
   localparam logic [9:0] VCR_OFS_SRC_TGT = 10'h008;
   localparam logic [9:0] VCR_OFS_CC_LO = 10'h00C;
   localparam logic [9:0] VCR_OFS_CC_HI = 10'h010;
   localparam logic [9:0] VCR_OFS_PC = 10'h014;
   localparam logic [9:0] VCR_OFS_CTRL = 10'h018;
   // general registers appear read-only from here upward, one word each
   localparam int unsigned VCR_GPR_WIN_BIT = 9;

   // ------------------------------------------------------------
   // constant registers and reset values
   // ------------------------------------------------------------
   localparam logic [6:0] VCR_ZERO_REG_IDX = 7'h00;
   localparam logic [6:0] VCR_ONE_REG_IDX = 7'h01;
   localparam logic [6:0] VCR_FIRST_GENERAL_IDX = 7'h02;
   localparam logic [31:0] VCR_ZERO_VALUE = 32'h0000_0000;
   localparam logic [31:0] VCR_ONE_VALUE = 32'h0000_0001;
   localparam logic [31:0] VCR_STATUS_RESET = 32'h0000_0800;
   localparam logic [31:0] VCR_PC_RESET = 32'h0000_0000;
   localparam logic [31:0] VCR_BTGT_RESET = 32'h0000_0000;
   localparam logic [31:0] VCR_UNMAPPED_VALUE = 32'h0000_0000;
   localparam int unsigned VCR_CS_BIT = 0;
   localparam logic VCR_CS_RESET = 1'b1;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [6:0] idx;
      logic [31:0] data;
   } vcr_gpr_wr_t;

   typedef struct packed {
      logic taken;
      logic interrupted;
      logic [31:0] target;
   } vcr_branch_t;

endpackage

/* File: hw/vcr_gpr_file.sv */
// Purpose: general register array with two operand ports and a peek port
// Assumes: one result write per cycle from the core
// Notes: operand reads are registered; the peek port is combinational

`timescale 1ns/10ps

module vcr_gpr_file #(
   parameter int unsigned NUM_REGS = 128
) (
   input wire logic core_clk_in,
   input wire vcr_pkg::vcr_gpr_wr_t wr_in,
   input wire logic [6:0] rd_a_idx_in,
   input wire logic [6:0] rd_b_idx_in,
   input wire logic [6:0] peek_idx_in,
   output logic [31:0] rd_a_data_out,
   output logic [31:0] rd_b_data_out,
   output logic [31:0] peek_data_out
);

   logic [31:0] regs [NUM_REGS];
   logic [31:0] next_rd_a_data;
   logic [31:0] next_rd_b_data;

   // constants override the array, so a stray write cannot leak out
   function automatic logic [31:0] gpr_value(input logic [6:0] idx);
      if (idx == vcr_pkg::VCR_ZERO_REG_IDX) begin
         return vcr_pkg::VCR_ZERO_VALUE;
      end else if (idx == vcr_pkg::VCR_ONE_REG_IDX) begin
         return vcr_pkg::VCR_ONE_VALUE;
      end
      return regs[idx];
   endfunction

   // operand and peek selection
   always_comb begin
      next_rd_a_data = gpr_value(rd_a_idx_in);
      next_rd_b_data = gpr_value(rd_b_idx_in);
      peek_data_out = gpr_value(peek_idx_in);
   end

   // array write: writes aimed at the constants are dropped
   always_ff @(posedge core_clk_in) begin
      if (wr_in.en && wr_in.idx >= vcr_pkg::VCR_FIRST_GENERAL_IDX) begin
         regs[wr_in.idx] <= wr_in.data;
      end
      rd_a_data_out <= next_rd_a_data;
      rd_b_data_out <= next_rd_b_data;
   end

endmodule // vcr_gpr_file

/* File: hw/vcr_cycle_counter.sv */
// Purpose: free-running or stall-aware cycle counter
// Assumes: stall input is synchronous to the core clock
// Notes: clears on synchronous reset

`timescale 1ns/10ps

module vcr_cycle_counter #(
   parameter int unsigned WIDTH = 64
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic count_stalls_in,
   input wire logic core_stall_in,
   output logic [WIDTH-1:0] count_out
);

   logic [WIDTH-1:0] next_count;

   // count every cycle, or only non-stall cycles
   always_comb begin
      next_count = count_out;
      if (count_stalls_in || !core_stall_in) begin
         next_count = count_out + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   // register; wraps silently at the top
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         count_out <= '0;
      end else begin
         count_out <= next_count;
      end
   end

endmodule // vcr_cycle_counter

/* File: hw/vcr_core_regs.sv */
// Purpose: architectural register model of a VLIW core as software sees it
// Assumes: core pipeline drives operand indices, results and branch events
// Notes: register port gives read data one cycle after the read strobe
//
// Summary of operation
// - 128 general registers of 32 bits
// - register zero always reads zero
// - register one always reads one
// - registers 2..127 carry no hardware role
// - four special registers besides program counter, plus a control word for the stall-count flag
// - control/status word is a 32-bit register
// - interrupted taken branch target goes to destination
// - completed taken branch target goes to source
// - 64-bit cycle counter, zero at reset
// - stall-count flag selects every or unstalled cycles
// - stall-count flag is one after reset
// - control/status word resets to 0x800

`timescale 1ns/10ps

module vcr_core_regs #(
   parameter int unsigned NUM_GPR = 128,
   parameter int unsigned CC_WIDTH = 64
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [9:0] bus_addr_in,
   input wire logic [31:0] bus_wdata_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   output logic [31:0] bus_rdata_out,
   // core side
   input wire vcr_pkg::vcr_gpr_wr_t gpr_wr_in,
   input wire logic [6:0] gpr_rd_a_idx_in,
   input wire logic [6:0] gpr_rd_b_idx_in,
   output logic [31:0] gpr_rd_a_data_out,
   output logic [31:0] gpr_rd_b_data_out,
   input wire vcr_pkg::vcr_branch_t branch_in,
   input wire logic pc_update_in,
   input wire logic [31:0] pc_next_in,
   input wire logic core_stall_in,
   output logic [31:0] pc_out,
   output logic [31:0] status_word_out,
   output logic [31:0] dest_target_out,
   output logic [31:0] src_target_out,
   output logic [CC_WIDTH-1:0] cycle_count_out,
   output logic count_stalls_out
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [31:0] next_status_word;
   logic [31:0] next_dest_target;
   logic [31:0] next_src_target;
   logic [31:0] next_pc;
   logic next_count_stalls;
   logic [31:0] cc_hi_shadow;
   logic [31:0] next_cc_hi_shadow;
   logic [31:0] next_rdata;
   logic [31:0] peek_data;
   logic [6:0] peek_idx;
   logic gpr_window;

   // exact offset match, used by every special-register read and write decode (not the window)
   function automatic logic reg_hit(input logic [9:0] addr, input logic [9:0] ofs);
      return addr == ofs;
   endfunction

   // ------------------------------------------------------------
   // general registers and cycle counter
   // ------------------------------------------------------------
   assign gpr_window = bus_addr_in[vcr_pkg::VCR_GPR_WIN_BIT];
   assign peek_idx = bus_addr_in[8:2];

   vcr_gpr_file #(
      .NUM_REGS(NUM_GPR)
   ) u_gpr (
      .core_clk_in(core_clk_in),
      .wr_in(gpr_wr_in),
      .rd_a_idx_in(gpr_rd_a_idx_in),
      .rd_b_idx_in(gpr_rd_b_idx_in),
      .peek_idx_in(peek_idx),
      .rd_a_data_out(gpr_rd_a_data_out),
      .rd_b_data_out(gpr_rd_b_data_out),
      .peek_data_out(peek_data)
   );

   vcr_cycle_counter #(
      .WIDTH(CC_WIDTH)
   ) u_cc (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .count_stalls_in(count_stalls_out),
      .core_stall_in(core_stall_in),
      .count_out(cycle_count_out)
   );

   // ------------------------------------------------------------
   // special registers: next values
   // ------------------------------------------------------------
   // hardware branch capture is applied after the software write, so an
   // event landing in the same cycle as a write is never lost
   always_comb begin
      next_status_word = status_word_out;
      next_dest_target = dest_target_out;
      next_src_target = src_target_out;
      next_count_stalls = count_stalls_out;
      next_pc = pc_out;
      if (bus_wr_in && reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_STATUS)) begin
         next_status_word = bus_wdata_in;
      end
      if (bus_wr_in && reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_DEST_TGT)) begin
         next_dest_target = bus_wdata_in;
      end
      if (bus_wr_in && reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_SRC_TGT)) begin
         next_src_target = bus_wdata_in;
      end
      if (bus_wr_in && reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_CTRL)) begin
         next_count_stalls = bus_wdata_in[vcr_pkg::VCR_CS_BIT];
      end
      if (branch_in.taken && branch_in.interrupted) begin
         next_dest_target = branch_in.target;
      end
      if (branch_in.taken && !branch_in.interrupted) begin
         next_src_target = branch_in.target;
      end
      if (pc_update_in) begin
         next_pc = pc_next_in;
      end
   end

   // ------------------------------------------------------------
   // register port read path
   // ------------------------------------------------------------
   // reading the low counter word freezes the high word, so a low-high
   // pair is coherent even across a carry between the two reads
   always_comb begin
      next_cc_hi_shadow = cc_hi_shadow;
      next_rdata = vcr_pkg::VCR_UNMAPPED_VALUE;
      if (bus_rd_in) begin
         if (gpr_window) begin
            next_rdata = peek_data;
         end else if (reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_STATUS)) begin
            next_rdata = status_word_out;
         end else if (reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_DEST_TGT)) begin
            next_rdata = dest_target_out;
         end else if (reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_SRC_TGT)) begin
            next_rdata = src_target_out;
         end else if (reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_CC_LO)) begin
            next_rdata = cycle_count_out[31:0];
            next_cc_hi_shadow = cycle_count_out[63:32];
         end else if (reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_CC_HI)) begin
            next_rdata = cc_hi_shadow;
         end else if (reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_PC)) begin
            next_rdata = pc_out;
         end else if (reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_CTRL)) begin
            next_rdata = {31'h0000_0000, count_stalls_out};
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // every flop here resets synchronously, status word to 0x800 and stall-count flag to one; the general register array has no reset
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         status_word_out <= vcr_pkg::VCR_STATUS_RESET;
         dest_target_out <= vcr_pkg::VCR_BTGT_RESET;
         src_target_out <= vcr_pkg::VCR_BTGT_RESET;
         pc_out <= vcr_pkg::VCR_PC_RESET;
         count_stalls_out <= vcr_pkg::VCR_CS_RESET;
         cc_hi_shadow <= vcr_pkg::VCR_ZERO_VALUE;
         bus_rdata_out <= vcr_pkg::VCR_ZERO_VALUE;
      end else begin
         status_word_out <= next_status_word;
         dest_target_out <= next_dest_target;
         src_target_out <= next_src_target;
         pc_out <= next_pc;
         count_stalls_out <= next_count_stalls;
         cc_hi_shadow <= next_cc_hi_shadow;
         bus_rdata_out <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // a result written to a general register, read back next cycle
   sequence s_gpr_wr_then_rd;
      gpr_wr_in.en && gpr_wr_in.idx >= vcr_pkg::VCR_FIRST_GENERAL_IDX
      ##1 gpr_rd_a_idx_in == $past(gpr_wr_in.idx);
   endsequence

   property p_gpr_wr_rd;
      s_gpr_wr_then_rd |=> gpr_rd_a_data_out == $past(gpr_wr_in.data, 2);
   endproperty
   a_gpr_wr_rd: assert property (p_gpr_wr_rd)
      else $error("general register did not return written value");

   property p_zero_read;
      gpr_rd_a_idx_in == vcr_pkg::VCR_ZERO_REG_IDX |=>
         gpr_rd_a_data_out == vcr_pkg::VCR_ZERO_VALUE;
   endproperty
   a_zero_read: assert property (p_zero_read)
      else $error("zero register read nonzero");

   property p_one_read;
      gpr_rd_b_idx_in == vcr_pkg::VCR_ONE_REG_IDX |=>
         gpr_rd_b_data_out == vcr_pkg::VCR_ONE_VALUE;
   endproperty
   a_one_read: assert property (p_one_read)
      else $error("one register read other than one");

   // a general register seen through the register port window
   sequence s_gpr_wr_then_peek;
      gpr_wr_in.en && gpr_wr_in.idx >= vcr_pkg::VCR_FIRST_GENERAL_IDX
      ##1 bus_rd_in && gpr_window && peek_idx == $past(gpr_wr_in.idx)
         && !(gpr_wr_in.en && gpr_wr_in.idx == peek_idx);
   endsequence

   property p_gpr_peek;
      s_gpr_wr_then_peek |=> bus_rdata_out == $past(gpr_wr_in.data, 2);
   endproperty
   a_gpr_peek: assert property (p_gpr_peek)
      else $error("register window returned stale general register");

   property p_pc_load;
      pc_update_in |=> pc_out == $past(pc_next_in);
   endproperty
   a_pc_load: assert property (p_pc_load)
      else $error("program counter did not load");

   sequence s_status_wr_then_rd;
      bus_wr_in && reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_STATUS)
      ##1 bus_rd_in && reg_hit(bus_addr_in, vcr_pkg::VCR_OFS_STATUS);
   endsequence

   property p_status_rw;
      s_status_wr_then_rd |=> bus_rdata_out == $past(bus_wdata_in, 2);
   endproperty
   a_status_rw: assert property (p_status_rw)
      else $error("status word read back differs from write");

   property p_dest_capture;
      branch_in.taken && branch_in.interrupted |=>
         dest_target_out == $past(branch_in.target);
   endproperty
   a_dest_capture: assert property (p_dest_capture)
      else $error("interrupted branch target not captured");

   property p_src_capture;
      branch_in.taken && !branch_in.interrupted |=>
         src_target_out == $past(branch_in.target);
   endproperty
   a_src_capture: assert property (p_src_capture)
      else $error("completed branch target not captured");

   property p_cc_from_reset;
      $rose(rst_n_in) |-> cycle_count_out == '0 ##1 cycle_count_out == CC_WIDTH'(1);
   endproperty
   a_cc_from_reset: assert property (p_cc_from_reset)
      else $error("cycle counter did not start from zero");

   property p_cc_advance;
      count_stalls_out || !core_stall_in |=>
         cycle_count_out == $past(cycle_count_out) + CC_WIDTH'(1);
   endproperty
   a_cc_advance: assert property (p_cc_advance)
      else $error("cycle counter failed to advance");

   property p_cc_hold;
      !count_stalls_out && core_stall_in |=> $stable(cycle_count_out);
   endproperty
   a_cc_hold: assert property (p_cc_hold)
      else $error("cycle counter advanced on stall");

   property p_cs_reset;
      $rose(rst_n_in) |-> count_stalls_out;
   endproperty
   a_cs_reset: assert property (p_cs_reset)
      else $error("stall-count flag not one after reset");

   property p_status_reset;
      $rose(rst_n_in) |-> status_word_out == vcr_pkg::VCR_STATUS_RESET;
   endproperty
   a_status_reset: assert property (p_status_reset)
      else $error("status word reset value wrong");

   // only the seven words from status up to control answer; the rest of the low page reads zero
   property p_unmapped_rd;
      bus_rd_in && !gpr_window && bus_addr_in > vcr_pkg::VCR_OFS_CTRL |=>
         bus_rdata_out == vcr_pkg::VCR_UNMAPPED_VALUE;
   endproperty
   a_unmapped_rd: assert property (p_unmapped_rd)
      else $error("unmapped register port read returned data");

   // read data stands one cycle only, so a stale word is never taken twice
   property p_rdata_idle;
      !bus_rd_in |=> bus_rdata_out == vcr_pkg::VCR_UNMAPPED_VALUE;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data stood beyond its cycle");

endmodule // vcr_core_regs

/* File: tb/vliw_core_register_model_bench.sv */
// Purpose: self-checking bench for the core register model
// Assumes: register port answers one cycle after a read strobe, never waits
// Notes: core-side inputs are driven straight from the bench, no partner

`timescale 1ns/10ps

module vliw_core_register_model_bench;
   logic core_clk_in;
   logic rst_n_in;
   logic [9:0] bus_addr_in;
   logic [31:0] bus_wdata_in;
   logic bus_wr_in;
   logic bus_rd_in;
   logic [31:0] bus_rdata_out;
   vcr_pkg::vcr_gpr_wr_t gpr_wr_in;
   logic [6:0] gpr_rd_a_idx_in;
   logic [6:0] gpr_rd_b_idx_in;
   logic [31:0] gpr_rd_a_data_out;
   logic [31:0] gpr_rd_b_data_out;
   vcr_pkg::vcr_branch_t branch_in;
   logic pc_update_in;
   logic [31:0] pc_next_in;
   logic core_stall_in;
   logic [31:0] pc_out;
   logic [31:0] status_word_out;
   logic [31:0] dest_target_out;
   logic [31:0] src_target_out;
   logic [63:0] cycle_count_out;
   logic count_stalls_out;
   int fail_count = 0;
   int n_tests = 0;

   // ----------------------------------------
   // design and clock
   // ----------------------------------------
   vcr_core_regs dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in),
      .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out), .gpr_wr_in(gpr_wr_in),
      .gpr_rd_a_idx_in(gpr_rd_a_idx_in), .gpr_rd_b_idx_in(gpr_rd_b_idx_in),
      .gpr_rd_a_data_out(gpr_rd_a_data_out), .gpr_rd_b_data_out(gpr_rd_b_data_out),
      .branch_in(branch_in), .pc_update_in(pc_update_in), .pc_next_in(pc_next_in),
      .core_stall_in(core_stall_in), .pc_out(pc_out), .status_word_out(status_word_out),
      .dest_target_out(dest_target_out), .src_target_out(src_target_out),
      .cycle_count_out(cycle_count_out),
      .count_stalls_out(count_stalls_out));

   // 25 MHz core clock
   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // one-cycle write strobe, new value visible after the taking edge
   task automatic bus_write(input logic [9:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      bus_wr_in <= 1'b1;
      bus_addr_in <= a;
      bus_wdata_in <= d;
      @(posedge core_clk_in);
      bus_wr_in <= 1'b0;
      @(negedge core_clk_in);
   endtask

   // data is only valid in the cycle after the strobe, so sample there
   task automatic bus_read(input logic [9:0] a, output logic [31:0] d);
      @(posedge core_clk_in);
      bus_rd_in <= 1'b1;
      bus_addr_in <= a;
      @(posedge core_clk_in);
      bus_rd_in <= 1'b0;
      @(negedge core_clk_in);
      d = bus_rdata_out;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_values();
      logic [31:0] d;
      check("status word", status_word_out, 64'h800);
      check("flag", count_stalls_out, 64'h1);
      check("count", cycle_count_out, 64'h0);
      check("pc", pc_out, 64'h0);
      // release on a rising edge, like every other input
      @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      bus_read(vcr_pkg::VCR_OFS_STATUS, d);
      check("status rd", d, 64'h800);
      bus_read(vcr_pkg::VCR_OFS_CTRL, d);
      check("ctrl rd", d[0], 64'h1);
      $display("test reset values done");
   endtask

   task automatic t_specials();
      logic [31:0] d;
      // all four special words writable or readable, others refused
      bus_write(vcr_pkg::VCR_OFS_STATUS, 32'hA5A5_0F0F);
      check("status out", status_word_out, 64'hA5A5_0F0F);
      bus_read(vcr_pkg::VCR_OFS_STATUS, d);
      check("status rd", d, 64'hA5A5_0F0F);
      // write then read with no gap; data taken in its single cycle
      @(posedge core_clk_in);
      bus_wr_in <= 1'b1;
      bus_addr_in <= vcr_pkg::VCR_OFS_STATUS;
      bus_wdata_in <= 32'h5A5A_F0F0;
      @(posedge core_clk_in);
      bus_wr_in <= 1'b0;
      bus_rd_in <= 1'b1;
      @(posedge core_clk_in);
      bus_rd_in <= 1'b0;
      @(negedge core_clk_in);
      check("status b2b", bus_rdata_out, 64'h5A5A_F0F0);
      @(negedge core_clk_in);
      check("rdata idle", bus_rdata_out, 64'h0);
      bus_write(vcr_pkg::VCR_OFS_DEST_TGT, 32'h1234_5678);
      bus_write(vcr_pkg::VCR_OFS_SRC_TGT, 32'h8765_4321);
      bus_read(vcr_pkg::VCR_OFS_DEST_TGT, d);
      check("dest rd", d, 64'h1234_5678);
      bus_read(vcr_pkg::VCR_OFS_SRC_TGT, d);
      check("src rd", d, 64'h8765_4321);
      bus_read(vcr_pkg::VCR_OFS_CC_HI, d);
      check("cc hi", d, 64'h0);
      bus_read(vcr_pkg::VCR_OFS_CC_LO, d);
      check("cc lo nonzero", d != 0, 64'h1);
      bus_read(10'h01C, d);
      check("unmapped", d, 64'h0);
      bus_write(vcr_pkg::VCR_OFS_PC, 32'hFFFF_FFFF);
      check("pc ro", pc_out, 64'h0);
      $display("test special registers done");
   endtask

   task automatic t_pc();
      @(posedge core_clk_in);
      pc_update_in <= 1'b1;
      pc_next_in <= 32'hDEAD_BEE0;
      @(posedge core_clk_in);
      pc_update_in <= 1'b0;
      pc_next_in <= 32'h0000_0004;
      @(negedge core_clk_in);
      check("pc load", pc_out, 64'hDEAD_BEE0);
      repeat (2) @(negedge core_clk_in);
      check("pc hold", pc_out, 64'hDEAD_BEE0);
      $display("test program counter done");
   endtask

   task automatic t_gpr();
      logic [6:0] idx [5] = '{7'h02, 7'h05, 7'h40, 7'h7E, 7'h7F};
      logic [31:0] d;
      // the core never names the constant registers as destination
      foreach (idx[i]) begin
         @(posedge core_clk_in);
         gpr_wr_in <= '{en: 1'b1, idx: idx[i], data: {8'hC0, 17'h0, idx[i]}};
         @(posedge core_clk_in);
         gpr_wr_in <= '0;
         gpr_rd_a_idx_in <= idx[i];
         gpr_rd_b_idx_in <= (i % 2 == 0) ? vcr_pkg::VCR_ZERO_REG_IDX : vcr_pkg::VCR_ONE_REG_IDX;
         // window read right behind the write must already see the new word
         bus_rd_in <= 1'b1;
         bus_addr_in <= {1'b1, idx[i], 2'b00};
         @(posedge core_clk_in);
         bus_rd_in <= 1'b0;
         @(negedge core_clk_in);
         check("gpr a", gpr_rd_a_data_out, {32'h0, 8'hC0, 17'h0, idx[i]});
         check("gpr b const", gpr_rd_b_data_out, (i % 2 == 0) ? 64'h0 : 64'h1);
         check("gpr peek", bus_rdata_out, {32'h0, 8'hC0, 17'h0, idx[i]});
         bus_read({1'b1, idx[i], 2'b00}, d);
         check("gpr window", d, {32'h0, 8'hC0, 17'h0, idx[i]});
      end
      bus_read({1'b1, 7'h00, 2'b00}, d);
      check("zero window", d, 64'h0);
      bus_read({1'b1, 7'h01, 2'b00}, d);
      check("one window", d, 64'h1);
      $display("test general registers done");
   endtask

   task automatic t_branch();
      logic [31:0] d;
      // interrupted then completed, back to back
      @(posedge core_clk_in);
      branch_in <= '{taken: 1'b1, interrupted: 1'b1, target: 32'h0000_1000};
      @(posedge core_clk_in);
      branch_in <= '{taken: 1'b1, interrupted: 1'b0, target: 32'h0000_2000};
      @(posedge core_clk_in);
      branch_in <= '{taken: 1'b0, interrupted: 1'b1, target: 32'h0000_3000};
      @(posedge core_clk_in);
      branch_in <= '0;
      @(negedge core_clk_in);
      check("dest target", dest_target_out, 64'h1000);
      check("src target", src_target_out, 64'h2000);
      bus_read(vcr_pkg::VCR_OFS_DEST_TGT, d);
      check("dest rd", d, 64'h1000);
      bus_read(vcr_pkg::VCR_OFS_SRC_TGT, d);
      check("src rd", d, 64'h2000);
      $display("test branch capture done");
   endtask

   // advance over five cycles under a given flag and stall level
   task automatic count_span(input logic flag, input logic stall, input logic [63:0] exp);
      logic [63:0] c0;
      bus_write(vcr_pkg::VCR_OFS_CTRL, {31'h0, flag});
      @(posedge core_clk_in);
      core_stall_in <= stall;
      @(negedge core_clk_in);
      c0 = cycle_count_out;
      repeat (5) @(negedge core_clk_in);
      check("count step", cycle_count_out - c0, exp);
      @(posedge core_clk_in);
      core_stall_in <= 1'b0;
   endtask

   task automatic t_counter();
      count_span(1'b1, 1'b1, 64'h5);
      count_span(1'b0, 1'b1, 64'h0);
      count_span(1'b0, 1'b0, 64'h5);
      count_span(1'b1, 1'b0, 64'h5);
      $display("test cycle counter done");
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      rst_n_in = 1'b0;
      bus_addr_in = '0;
      bus_wdata_in = '0;
      bus_wr_in = 1'b0;
      bus_rd_in = 1'b0;
      gpr_wr_in = '0;
      gpr_rd_a_idx_in = '0;
      gpr_rd_b_idx_in = '0;
      branch_in = '0;
      pc_update_in = 1'b0;
      pc_next_in = '0;
      core_stall_in = 1'b0;
      repeat (12) @(posedge core_clk_in);
      @(negedge core_clk_in);
      t_reset_values();
      t_specials();
      t_pc();
      t_gpr();
      t_branch();
      t_counter();
      close_out();
   end

   // a hang counts as a mismatch and ends the run
   initial begin
      repeat (20000) @(posedge core_clk_in);
      fail_count++;
      $display("ERROR watchdog expected finish seen hang");
      close_out();
   end
endmodule // vliw_core_register_model_bench
